// file: dv/boot_loader_checker.sv
// Concurrent checks on the boot loader ports.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/100ps
module boot_loader_checker #(
	parameter OTP_AW = 11,
	parameter SRAM_AW = 15
) (
	input wire ref_clk_i,
	input wire nrst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire otp_rd_o,
	input wire otp_sec_o,
	input wire [31:0] otp_rdata_i,
	input wire otp_rvalid_i,
	input wire otp_prog_o,
	input wire [15:0] otp_prog_addr_o,
	input wire sram_we_o,
	input wire [SRAM_AW-1:0] sram_addr_o,
	input wire core_run_o,
	input wire boot_err_o,
	input wire gpio_pd_o,
	input wire jtag_block_o,
	input wire link_block_o,
	input wire otp_redundant_o,
	input wire jtag_otp_block_o
);
	// ==========================================
	// Helper state
	// ==========================================
	reg [10:0] since_q; // Cycles since release, saturating.
	reg [31:0] sec_q; // Security word as the OTP returned it.
	reg wr_seen_q; // High once the first SRAM write passed.
	// Track release time, the loaded word and the first write.
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			since_q <= 11'h000;
			sec_q <= 32'h00000000;
			wr_seen_q <= 1'b0;
		end else begin
			if (since_q != 11'h7ff) begin
				since_q <= since_q + 11'h001;
			end
			if (otp_rvalid_i && otp_sec_o) begin
				sec_q <= otp_rdata_i;
			end
			if (sram_we_o) begin
				wr_seen_q <= 1'b1;
			end
		end
	end
	// ==========================================
	// Assertions
	// ==========================================
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	a_pd_at_release: assert property ($rose(nrst_i) |-> gpio_pd_o)
		else $error("pull-down not held through reset");
	a_boot_window: assert property (otp_rd_o && otp_sec_o |->
		since_q >= 11'd150 && since_q <= 11'd1500)
		else $error("boot began outside its window");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	// The loaded word reaches the block outputs two edges after the answer.
	a_sec_applied: assert property (otp_rvalid_i && otp_sec_o |->
		##2 (jtag_block_o == sec_q[0] && link_block_o == sec_q[1]))
		else $error("access blocks differ from loaded word");
	a_otp_guards: assert property (otp_rvalid_i && otp_sec_o |->
		##2 (otp_redundant_o == sec_q[7] && jtag_otp_block_o == sec_q[13]))
		else $error("OTP guards differ from loaded word");
	a_first_sram: assert property (sram_we_o && !wr_seen_q |->
		sram_addr_o == 0)
		else $error("first SRAM write not at address zero");
	a_err_no_run: assert property (boot_err_o |-> !core_run_o)
		else $error("program runs despite boot error");
	a_prog_locks: assert property (otp_prog_o |-> !sec_q[12] &&
		(otp_prog_addr_o[15] || !sec_q[8 + otp_prog_addr_o[10:9]]))
		else $error("programming passed a lock");
endmodule

bind boot_loader boot_loader_checker #(.OTP_AW(OTP_AW),
	.SRAM_AW(SRAM_AW)) chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.otp_rd_o(otp_rd_o), .otp_sec_o(otp_sec_o),
	.otp_rdata_i(otp_rdata_i), .otp_rvalid_i(otp_rvalid_i),
	.otp_prog_o(otp_prog_o), .otp_prog_addr_o(otp_prog_addr_o),
	.sram_we_o(sram_we_o), .sram_addr_o(sram_addr_o),
	.core_run_o(core_run_o), .boot_err_o(boot_err_o),
	.gpio_pd_o(gpio_pd_o), .jtag_block_o(jtag_block_o),
	.link_block_o(link_block_o), .otp_redundant_o(otp_redundant_o),
	.jtag_otp_block_o(jtag_otp_block_o));

// file: dv/boot_partner.sv
// Model of the boot flash and the OTP store seen by the loader.
// Assumes the bench fills img before each reset release.
`timescale 1ns/100ps
module boot_partner (
	input wire ref_clk_i,
	input wire nrst_i,
	input wire slow_i,
	input wire [31:0] sec_word_i,
	input wire otp_rd_i,
	input wire otp_sec_i,
	input wire [10:0] otp_addr_i,
	output reg [31:0] otp_rdata_o,
	output reg otp_rvalid_o,
	input wire flash_req_i,
	output wire [7:0] flash_byte_o,
	output wire flash_valid_o
);
	// ==========================================
	// Flash byte stream
	// ==========================================
	reg [7:0] img [0:63]; // Image bytes, count first.
	reg [5:0] ptr_q; // Next byte to hand out.
	reg tog_q; // Stall phase in slow mode.
	// Bytes go out in stored order, stalling each other cycle if slow.
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ptr_q <= 6'h00;
			tog_q <= 1'b0;
		end else begin
			tog_q <= ~tog_q;
			if (flash_req_i && flash_valid_o) begin
				ptr_q <= ptr_q + 6'h01;
			end
		end
	end
	assign flash_valid_o = flash_req_i && (!slow_i || tog_q);
	// Outside a valid byte the data lines show the inverse.
	assign flash_byte_o = flash_valid_o ? img[ptr_q] : ~img[ptr_q];
	// ==========================================
	// OTP reads
	// ==========================================
	reg [1:0] wait_q; // Cycles left before the answer.
	reg sec_q; // The pending read targets the security row.
	reg [10:0] row_q; // Pending row of the 2048-row store.
	// Answer each read late; data toggles when not answering.
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wait_q <= 2'h0;
			sec_q <= 1'b0;
			row_q <= 11'h000;
			otp_rvalid_o <= 1'b0;
			otp_rdata_o <= 32'h00000000;
		end else begin
			otp_rvalid_o <= 1'b0;
			otp_rdata_o <= ~otp_rdata_o;
			if (otp_rd_i) begin
				wait_q <= slow_i ? 2'h3 : 2'h1;
				sec_q <= otp_sec_i;
				row_q <= otp_addr_i;
			end else if (wait_q != 2'h0) begin
				wait_q <= wait_q - 2'h1;
				if (wait_q == 2'h1) begin
					otp_rvalid_o <= 1'b1;
					otp_rdata_o <= sec_q ? sec_word_i :
						{21'h000000, row_q} ^ 32'h5a5a0000;
				end
			end
		end
	end
endmodule

// file: dv/tb.sv
// Self-checking bench: flash boots, OTP boot and programming gate.
// Assumes the partner model answers both OTP and flash.
`timescale 1ns/100ps
module tb;
	reg ref_clk_i = 1'b0;
	reg nrst_i = 1'b0;
	reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	reg [7:0] wb_adr_i = 8'h00;
	reg [3:0] wb_sel_i = 4'hf;
	reg [31:0] wb_dat_i = 32'h00000000, sec_word = 32'h00000000;
	reg slow = 1'b0;
	wire [31:0] wb_dat_o, otp_rdata_i, otp_prog_data_o, sram_wdata_o;
	wire [10:0] otp_addr_o;
	wire [15:0] otp_prog_addr_o;
	wire [14:0] sram_addr_o;
	wire [7:0] flash_byte_i;
	wire wb_ack_o, otp_rd_o, otp_sec_o, otp_rvalid_i, otp_prog_o;
	wire flash_req_o, flash_valid_i, sram_we_o, core_run_o, boot_err_o;
	wire gpio_pd_o, jtag_block_o, link_block_o, otp_redundant_o;
	wire jtag_otp_block_o;
	reg [31:0] mem [0:2047]; // SRAM as seen through writes.
	reg [31:0] q, n0; // Read data and a saved program count.
	integer err_total = 0, n_checks = 0, nprog = 0, cycles = 0;
	boot_loader dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .otp_rd_o(otp_rd_o),
		.otp_sec_o(otp_sec_o), .otp_addr_o(otp_addr_o),
		.otp_rdata_i(otp_rdata_i), .otp_rvalid_i(otp_rvalid_i),
		.otp_prog_o(otp_prog_o), .otp_prog_addr_o(otp_prog_addr_o),
		.otp_prog_data_o(otp_prog_data_o), .flash_req_o(flash_req_o),
		.flash_byte_i(flash_byte_i), .flash_valid_i(flash_valid_i),
		.sram_we_o(sram_we_o), .sram_addr_o(sram_addr_o),
		.sram_wdata_o(sram_wdata_o), .core_run_o(core_run_o),
		.boot_err_o(boot_err_o), .gpio_pd_o(gpio_pd_o),
		.jtag_block_o(jtag_block_o), .link_block_o(link_block_o),
		.otp_redundant_o(otp_redundant_o),
		.jtag_otp_block_o(jtag_otp_block_o));
	boot_partner fl (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.slow_i(slow), .sec_word_i(sec_word), .otp_rd_i(otp_rd_o),
		.otp_sec_i(otp_sec_o), .otp_addr_i(otp_addr_o),
		.otp_rdata_o(otp_rdata_i), .otp_rvalid_o(otp_rvalid_i),
		.flash_req_i(flash_req_o), .flash_byte_o(flash_byte_i),
		.flash_valid_o(flash_valid_i));
	// ==========================================
	// Clock, monitors and timeout
	// ==========================================
	initial begin
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	// Capture SRAM writes and count programming pulses.
	always @(posedge ref_clk_i) begin
		if (sram_we_o === 1'b1) mem[sram_addr_o[10:0]] <= sram_wdata_o;
		if (otp_prog_o === 1'b1) nprog <= nprog + 1;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			err_total = err_total + 1;
			wrap_up;
		end
	end
	// ==========================================
	// Tasks
	// ==========================================
	task chk(input [31:0] seen, input [31:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One classic Wishbone cycle, held until ack is sampled.
	task bus(input w, input [7:0] a, input [31:0] d);
		@(posedge ref_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task put32(input integer a, input [31:0] v);
		integer k;
		for (k = 0; k < 4; k = k + 1) fl.img[a + k] = v[8 * k +: 8];
	endtask
	// Image of s words; kind 1 spoils the checksum, 2 skips it.
	task mk(input integer s, input integer kind);
		integer i, j;
		reg [31:0] c;
		put32(0, s);
		for (i = 0; i < s; i = i + 1) begin
			put32(4 + 4 * i, 32'ha5000000 + i * 32'h01010101);
		end
		c = 32'hffffffff;
		for (i = 0; i < 4 + 4 * s; i = i + 1) begin
			c = c ^ fl.img[i];
			for (j = 0; j < 8; j = j + 1) begin
				c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
			end
		end
		c = ~c ^ (kind == 1);
		put32(4 + 4 * s, kind == 2 ? 32'h0d15ab1e : c);
	endtask
	// Reset with a given security word, then wait for run or error.
	task boot(input [31:0] sw, input sl);
		integer k;
		nrst_i <= 1'b0;
		sec_word <= sw;
		slow <= sl;
		// Reset held well past the supply settling the driver owes us.
		repeat (16) @(posedge ref_clk_i);
		chk(gpio_pd_o, 1);
		nrst_i <= 1'b1;
		k = 0;
		while (core_run_o !== 1'b1 && boot_err_o !== 1'b1 && k < 20000) begin
			@(posedge ref_clk_i);
			k = k + 1;
		end
		// A boot that never ends counts as a mismatch.
		if (k == 20000) err_total = err_total + 1;
		@(posedge ref_clk_i);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ==========================================
	// Scenarios
	// ==========================================
	initial begin
		mk(2, 0);
		boot(32'h00400103, 1'b0);
		chk(core_run_o, 1);
		chk(mem[1], 32'ha6010101);
		bus(0, 8'h00, 0);
		chk(q, 32'h00400103);
		bus(0, 8'h08, 0);
		chk(q, 32'h00400000);
		bus(0, 8'h40, 0);
		chk(q, 0);
		chk({gpio_pd_o, jtag_block_o, link_block_o}, 3'h3);
		chk({otp_redundant_o, jtag_otp_block_o}, 2'h0);
		n0 = nprog;
		bus(1, 8'h0c, 32'h00000000);
		bus(1, 8'h10, 32'hcafe0001);
		bus(1, 8'h14, 1);
		bus(0, 8'h04, 0);
		chk(q[9:6], 4'hd);
		chk(nprog, n0);
		bus(1, 8'h0c, 32'h00000200);
		bus(1, 8'h14, 3);
		bus(0, 8'h04, 0);
		chk({q[9], otp_prog_addr_o}, {1'b0, 16'h0200});
		chk(nprog, n0 + 1);
		chk(otp_prog_data_o, 32'hcafe0001);
		mk(1, 1);
		boot(0, 1'b1);
		chk({boot_err_o, core_run_o, jtag_block_o}, 3'h4);
		mk(3, 2);
		boot(0, 1'b0);
		chk(core_run_o, 1);
		chk(mem[2], 32'ha7020202);
		mk(0, 0);
		boot(0, 1'b0);
		chk(core_run_o, 1);
		boot(32'h000030a0, 1'b0);
		chk({core_run_o, fl.ptr_q}, 7'h40);
		chk(mem[2047], 32'h5a5a07ff);
		chk({otp_redundant_o, jtag_otp_block_o, jtag_block_o}, 3'h6);
		n0 = nprog;
		bus(1, 8'h0c, 32'h00008000);
		bus(1, 8'h14, 1);
		bus(0, 8'h04, 0);
		chk(q[9], 1);
		chk(nprog, n0);
		wrap_up;
	end
endmodule

// file: hdl/boot_defines.vh
// Constants shared by the boot loader and its checksum engine.
// Assumes a single 10 MHz tile clock and word-aligned bus offsets.
`ifndef BOOT_DEFINES_VH
`define BOOT_DEFINES_VH

// ========================================================
// Timing
// ========================================================
// Clock rate in MHz.
`define CLK_MHZ 10
// Least delay from reset release to boot, in microseconds.
`define RST_SEQ_US 15
// Delay in clock cycles, microseconds times the clock rate in MHz.
`define RST_SEQ_CYC (`RST_SEQ_US * `CLK_MHZ)

// ========================================================
// Register byte offsets
// ========================================================
`define REG_SEC 8'h00
`define REG_STATUS 8'h04
`define REG_USERCODE 8'h08
`define REG_PROG_ADDR 8'h0c
`define REG_PROG_DATA 8'h10
`define REG_PROG_CTRL 8'h14

// ========================================================
// Security register fields
// ========================================================
`define SEC_JTAG_OFF 0
`define SEC_LINK_OFF 1
`define SEC_OTP_BOOT 5
`define SEC_REDUNDANT 7
`define SEC_LOCK0 8
`define SEC_MASTER_LOCK 12
`define SEC_JTAG_OTP_OFF 13
`define SEC_UID_LSB 22
`define SEC_UID_MSB 31

// ========================================================
// Image and checksum
// ========================================================
`define CRC_SKIP 32'h0d15ab1e
`define CRC_POLY 32'hedb88320
`define CRC_INIT 32'hffffffff

// ========================================================
// Programming port identifiers and control fields
// ========================================================
`define OTP_ADDR_PORT_ID 24'h100200
`define OTP_DATA_PORT_ID 24'h200100
`define OTP_CTRL_PORT_ID 24'h100300
`define CTRL_GO 0
`define CTRL_CLR_ERR 1
`define PADDR_SEC 15

`endif

// file: hdl/boot_loader.v
// Tile boot loader: security load, OTP or flash boot, OTP program gate.
// Assumes OTP answers reads with a valid strobe, flash streams bytes
// on request and SRAM takes one word write per cycle.
`timescale 1ns/100ps
`include "boot_defines.vh"

module boot_loader #(
	parameter OTP_AW = 11,
	parameter SRAM_AW = 15,
	parameter [21:0] SILICON_REV = 22'h000000
) (
	input wire ref_clk_i,
	input wire nrst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg otp_rd_o,
	output reg otp_sec_o,
	output reg [OTP_AW-1:0] otp_addr_o,
	input wire [31:0] otp_rdata_i,
	input wire otp_rvalid_i,
	output reg otp_prog_o,
	output reg [15:0] otp_prog_addr_o,
	output reg [31:0] otp_prog_data_o,
	output reg flash_req_o,
	input wire [7:0] flash_byte_i,
	input wire flash_valid_i,
	output reg sram_we_o,
	output reg [SRAM_AW-1:0] sram_addr_o,
	output reg [31:0] sram_wdata_o,
	output reg core_run_o,
	output reg boot_err_o,
	output reg gpio_pd_o,
	output reg jtag_block_o,
	output reg link_block_o,
	output reg otp_redundant_o,
	output reg jtag_otp_block_o
);

	// ========================================================
	// States
	// ========================================================
	localparam [3:0] ST_RSEQ = 4'h0;
	localparam [3:0] ST_SEC = 4'h1;
	localparam [3:0] ST_PICK = 4'h2;
	localparam [3:0] ST_OTP = 4'h3;
	localparam [3:0] ST_FSIZE = 4'h4;
	localparam [3:0] ST_FPROG = 4'h5;
	localparam [3:0] ST_FCRC = 4'h6;
	localparam [3:0] ST_CHECK = 4'h7;
	localparam [3:0] ST_RUN = 4'h8;
	localparam [3:0] ST_ERR = 4'h9;
	// Full-width end count, cut to the counter's width on purpose.
	localparam [31:0] RSEQ_END = `RST_SEQ_CYC - 1;
	localparam [15:0] RSEQ_LAST = RSEQ_END[15:0];
	localparam [OTP_AW-1:0] OTP_LAST = {OTP_AW{1'b1}};

	reg [3:0] state_q; // Boot sequencer state.
	reg [15:0] rseq_q; // Reset sequence cycle count.
	reg rd_wait_q; // An OTP read is outstanding.
	reg [31:0] sec_q; // Loaded security register.
	reg sec_valid_q; // Security contents have been loaded.
	reg [1:0] bcnt_q; // Byte position within a word.
	reg [31:0] word_q; // Word being assembled.
	reg [31:0] left_q; // Program words still to come.
	reg crc_init_q; // Restarts the checksum engine.
	reg [15:0] paddr_q; // Programming address port.
	reg [31:0] pdata_q; // Programming data port.
	reg [15:0] pctrl_q; // Programming control port.
	reg perr_q; // Sticky refused programming flag.
	wire [31:0] crc; // Finished checksum.

	// ========================================================
	// Helpers
	// ========================================================
	// Merges write data into a register under byte enables.
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer i;
		begin
			lane_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					lane_merge[8*i +: 8] = nw[8*i +: 8];
				end
			end
		end
	endfunction

	// Byte handshake with the flash stream.
	wire take = flash_req_o & flash_valid_i;
	// Word with the new byte placed on top, low byte first.
	wire [31:0] word_nx = {flash_byte_i, word_q[31:8]};
	wire last_b = (bcnt_q == 2'b11);
	// Checksum covers count and program bytes only.
	wire crc_en = take & ((state_q == ST_FSIZE) | (state_q == ST_FPROG));

	crc32_byte u_crc (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.init_i(crc_init_q),
		.en_i(crc_en),
		.byte_i(flash_byte_i),
		.crc_o(crc)
	);

	// ========================================================
	// Bus decode
	// ========================================================
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i;
	wire wr_ctrl = bus_wr & (wb_adr_i == `REG_PROG_CTRL);
	wire go = wr_ctrl & wb_sel_i[0] & wb_dat_i[`CTRL_GO];
	wire clr = wr_ctrl & wb_sel_i[0] & wb_dat_i[`CTRL_CLR_ERR];
	// Sector of the programming address: 512 words each.
	wire [1:0] sector = paddr_q[10:9];
	wire to_sec = paddr_q[`PADDR_SEC];
	// Refused before the security load, on the master lock, or on the sector lock outside the security row.
	wire locked = ~sec_valid_q | sec_q[`SEC_MASTER_LOCK] |
		(~to_sec & sec_q[`SEC_LOCK0 + sector]);
	wire [31:0] user_code = {sec_q[`SEC_UID_MSB:`SEC_UID_LSB],
		SILICON_REV};
	// Merged write words for the 16-bit ports; only the low half is kept.
	wire [31:0] paddr_mg = lane_merge({16'h0000, paddr_q}, wb_dat_i,
		wb_sel_i);
	wire [31:0] pctrl_mg = lane_merge({16'h0000, pctrl_q}, wb_dat_i,
		wb_sel_i);

	// ========================================================
	// Boot sequencer
	// ========================================================
	// Walks reset delay, security load, then the chosen boot path.
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= ST_RSEQ;
			rseq_q <= 16'h0000;
			rd_wait_q <= 1'b0;
			sec_q <= 32'h00000000;
			sec_valid_q <= 1'b0;
			bcnt_q <= 2'b00;
			word_q <= 32'h00000000;
			left_q <= 32'h00000000;
			crc_init_q <= 1'b1;
			otp_rd_o <= 1'b0;
			otp_sec_o <= 1'b0;
			otp_addr_o <= {OTP_AW{1'b0}};
			flash_req_o <= 1'b0;
			sram_we_o <= 1'b0;
			sram_addr_o <= {SRAM_AW{1'b0}};
			sram_wdata_o <= 32'h00000000;
			core_run_o <= 1'b0;
			boot_err_o <= 1'b0;
			gpio_pd_o <= 1'b1;
		end else begin
			otp_rd_o <= 1'b0;
			sram_we_o <= 1'b0;
			crc_init_q <= 1'b0;
			case (state_q)
			ST_RSEQ: begin
				// Internal reset sequence before any boot step.
				if (rseq_q == RSEQ_LAST) begin
					state_q <= ST_SEC;
					gpio_pd_o <= 1'b0;
					otp_rd_o <= 1'b1;
					otp_sec_o <= 1'b1;
					rd_wait_q <= 1'b1;
				end else begin
					rseq_q <= rseq_q + 16'h0001;
				end
			end
			ST_SEC: begin
				// Security word is captured before anything uses it.
				if (otp_rvalid_i) begin
					sec_q <= otp_rdata_i;
					sec_valid_q <= 1'b1;
					// Restart the checksum now, well before the first byte.
					crc_init_q <= 1'b1;
					otp_sec_o <= 1'b0;
					rd_wait_q <= 1'b0;
					state_q <= ST_PICK;
				end
			end
			ST_PICK: begin
				if (sec_q[`SEC_OTP_BOOT]) begin
					state_q <= ST_OTP;
					otp_addr_o <= {OTP_AW{1'b0}};
					otp_rd_o <= 1'b1;
					rd_wait_q <= 1'b1;
				end else begin
					state_q <= ST_FSIZE;
					flash_req_o <= 1'b1;
				end
				bcnt_q <= 2'b00;
				sram_addr_o <= {SRAM_AW{1'b0}};
			end
			ST_OTP: begin
				// Copies each OTP word to the same SRAM word.
				if (rd_wait_q & otp_rvalid_i) begin
					sram_we_o <= 1'b1;
					sram_wdata_o <= otp_rdata_i;
					sram_addr_o <= {{(SRAM_AW-OTP_AW){1'b0}}, otp_addr_o};
					if (otp_addr_o == OTP_LAST) begin
						rd_wait_q <= 1'b0;
						state_q <= ST_RUN;
					end else begin
						otp_addr_o <= otp_addr_o + 1'b1;
						otp_rd_o <= 1'b1;
					end
				end
			end
			ST_FSIZE: begin
				// Gathers the program word count.
				if (take) begin
					word_q <= word_nx;
					bcnt_q <= bcnt_q + 2'b01;
					if (last_b) begin
						left_q <= word_nx;
						state_q <= (word_nx == 32'h00000000) ?
							ST_FCRC : ST_FPROG;
					end
				end
			end
			ST_FPROG: begin
				// Each full word lands at the next SRAM address.
				if (take) begin
					word_q <= word_nx;
					bcnt_q <= bcnt_q + 2'b01;
					if (last_b) begin
						sram_we_o <= 1'b1;
						sram_wdata_o <= word_nx;
						left_q <= left_q - 32'h00000001;
						if (left_q == 32'h00000001) begin
							state_q <= ST_FCRC;
						end
					end
				end
				if (sram_we_o) begin
					sram_addr_o <= sram_addr_o + 1'b1;
				end
			end
			ST_FCRC: begin
				// Trailing checksum; stream stops after its top byte.
				if (take) begin
					word_q <= word_nx;
					bcnt_q <= bcnt_q + 2'b01;
					if (last_b) begin
						flash_req_o <= 1'b0;
						state_q <= ST_CHECK;
					end
				end
			end
			ST_CHECK: begin
				// Magic word bypasses the comparison.
				if (word_q == `CRC_SKIP) begin
					state_q <= ST_RUN;
				end else if (word_q == crc) begin
					state_q <= ST_RUN;
				end else begin
					state_q <= ST_ERR;
				end
				sram_addr_o <= {SRAM_AW{1'b0}};
			end
			ST_RUN: begin
				// Processor starts at SRAM address zero.
				core_run_o <= 1'b1;
				sram_addr_o <= {SRAM_AW{1'b0}};
			end
			ST_ERR: begin
				boot_err_o <= 1'b1;
			end
			default: begin
				state_q <= ST_ERR;
			end
			endcase
		end
	end

	// ========================================================
	// Security outputs
	// ========================================================
	// Protections stay on until the loaded bits say otherwise.
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			jtag_block_o <= 1'b1;
			link_block_o <= 1'b1;
			otp_redundant_o <= 1'b0;
			jtag_otp_block_o <= 1'b1;
		end else begin
			jtag_block_o <= ~sec_valid_q | sec_q[`SEC_JTAG_OFF];
			link_block_o <= ~sec_valid_q | sec_q[`SEC_LINK_OFF];
			otp_redundant_o <= sec_valid_q & sec_q[`SEC_REDUNDANT];
			jtag_otp_block_o <= ~sec_valid_q |
				sec_q[`SEC_JTAG_OTP_OFF];
		end
	end

	// ========================================================
	// Programming ports
	// ========================================================
	// Issues a program strobe only when no lock applies.
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			otp_prog_o <= 1'b0;
			otp_prog_addr_o <= 16'h0000;
			otp_prog_data_o <= 32'h00000000;
			perr_q <= 1'b0;
		end else begin
			otp_prog_o <= go & ~locked;
			if (go & ~locked) begin
				otp_prog_addr_o <= paddr_q;
				otp_prog_data_o <= pdata_q;
			end
			// A refusal in the clearing cycle still sets the flag.
			if (go & locked) begin
				perr_q <= 1'b1;
			end else if (clr) begin
				perr_q <= 1'b0;
			end
		end
	end

	// ========================================================
	// Wishbone slave
	// ========================================================
	// Single-wait answer: ack one cycle after the strobe, then drop.
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			paddr_q <= 16'h0000;
			pdata_q <= 32'h00000000;
			pctrl_q <= 16'h0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h00000000;
			if (bus_wr) begin
				case (wb_adr_i)
				`REG_PROG_ADDR: begin
					paddr_q <= paddr_mg[15:0];
				end
				`REG_PROG_DATA: begin
					pdata_q <= lane_merge(pdata_q, wb_dat_i,
						wb_sel_i);
				end
				`REG_PROG_CTRL: begin
					pctrl_q <= pctrl_mg[15:0];
				end
				default: begin
					pctrl_q <= pctrl_q;
				end
				endcase
			end else if (bus_req) begin
				case (wb_adr_i)
				`REG_SEC: wb_dat_o <= sec_q;
				`REG_STATUS: wb_dat_o <= {22'h000000, perr_q,
					sec_valid_q, boot_err_o, core_run_o, 2'b00,
					state_q};
				`REG_USERCODE: wb_dat_o <= user_code;
				`REG_PROG_ADDR: wb_dat_o <= {16'h0000, paddr_q};
				`REG_PROG_DATA: wb_dat_o <= pdata_q;
				`REG_PROG_CTRL: wb_dat_o <= {16'h0000, pctrl_q};
				default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

// file: hdl/crc32_byte.v
// Byte-wide reflected CRC-32 register with synchronous restart.
// Assumes bytes arrive one per enable pulse, least significant bit first.
`timescale 1ns/100ps
`include "boot_defines.vh"

module crc32_byte (
	input wire ref_clk_i,
	input wire nrst_i,
	input wire init_i,
	input wire en_i,
	input wire [7:0] byte_i,
	output wire [31:0] crc_o
);

	// Running residue.
	reg [31:0] crc_q;

	// ========================================================
	// Step function
	// ========================================================
	// Folds one byte into the residue, bit 0 first.
	function [31:0] crc_step;
		input [31:0] c;
		input [7:0] b;
		integer i;
		reg [31:0] r;
		begin
			r = c ^ {24'h000000, b};
			for (i = 0; i < 8; i = i + 1) begin
				r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
			end
			crc_step = r;
		end
	endfunction

	// Residue starts all ones and absorbs each enabled byte outside a restart cycle.
	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			crc_q <= `CRC_INIT;
		end else if (init_i) begin
			crc_q <= `CRC_INIT;
		end else if (en_i) begin
			crc_q <= crc_step(crc_q, byte_i);
		end
	end

	// The finished checksum is the inverted residue.
	assign crc_o = ~crc_q;

endmodule
